/* rtl/tppio_defs.svh */
// Register offsets, reset values and widths for the three-port parallel I/O block
`ifndef TPPIO_DEFS_SVH
`define TPPIO_DEFS_SVH
`define TPPIO_IDX_C_DATA  4'h2
`define TPPIO_IDX_D_DATA  4'h3
`define TPPIO_IDX_C_DIR   4'h6
`define TPPIO_IDX_D_DIR   4'h7
`define TPPIO_IDX_E_DATA  4'h8
`define TPPIO_IDX_E_DIR   4'hC
`define TPPIO_IDX_MUX     4'hD
`define TPPIO_DIR_RESET   8'h00
`define TPPIO_MUX_RESET   8'h00
`define TPPIO_RESP_OKAY   2'b00
`define TPPIO_RESP_SLVERR 2'b10
`define TPPIO_ADDR_W      6
`define TPPIO_PS_EXTCLK   3'h7
`define TPPIO_MUX_SERIAL  0
`define TPPIO_MUX_KBDRV   1
`endif

/* rtl/tppio_pkg.sv */
// Types for the three-port parallel I/O block
package tppio_pkg;
  typedef logic [7:0] tppio_byte_t;
  typedef enum logic [1:0] {TPPIO_IDLE, TPPIO_WRESP, TPPIO_RRESP} tppio_bus_t;
  typedef struct packed {
    tppio_byte_t c_latch;
    tppio_byte_t d_latch;
    tppio_byte_t e_latch;
    tppio_byte_t c_dir;
    tppio_byte_t d_dir;
    tppio_byte_t e_dir;
    tppio_byte_t c_s1;
    tppio_byte_t c_s2;
    tppio_byte_t d_s1;
    tppio_byte_t d_s2;
    tppio_byte_t e_s1;
    tppio_byte_t e_s2;
    logic        aw_held;
    logic [5:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    tppio_bus_t  wr_state;
    tppio_bus_t  rd_state;
    logic [1:0]  b_resp;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
  } tppio_state_t;
endpackage

/* rtl/tppio_top.sv */
// Three byte-wide GPIO ports with pin sharing for timer, serial and keypad, AXI4-Lite registers
`timescale 1ns/100ps
`include "tppio_defs.svh"
module tppio_top (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // AXI4-Lite write address and data
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Port pins
  input  wire tppio_pkg::tppio_byte_t thirdPortBitsIn,
  output tppio_pkg::tppio_byte_t    thirdPortBitsOut,
  output tppio_pkg::tppio_byte_t    thirdPortBitsOe,
  input  wire tppio_pkg::tppio_byte_t fourthPortBitsIn,
  output tppio_pkg::tppio_byte_t    fourthPortBitsOut,
  output tppio_pkg::tppio_byte_t    fourthPortBitsOe,
  input  wire tppio_pkg::tppio_byte_t fifthPortBitsIn,
  output tppio_pkg::tppio_byte_t    fifthPortBitsOut,
  output tppio_pkg::tppio_byte_t    fifthPortBitsOe,
  // Keypad interrupt module
  input  wire tppio_pkg::tppio_byte_t keypadIrqEnables,
  output tppio_pkg::tppio_byte_t    keypadIrqInputs,
  // Timer module
  input  wire logic [7:0]           edgeLevelSelect,
  input  wire logic [3:0]           timerChannelOut,
  input  wire logic [3:0]           timerChannelOe,
  output logic [3:0]                timerChannelPins,
  input  wire logic [2:0]           prescalerSelect,
  output logic                      timerExternalClock,
  // Serial module
  input  wire logic                 serialModuleEnable,
  input  wire logic                 serialTxd,
  output logic                      serialRxd
);
  import tppio_pkg::*;

  tppio_state_t st_reg;
  tppio_state_t st_next;

  logic [3:0]  timerOwn;
  logic        clkOwn;
  logic        serOwn;
  tppio_byte_t eDrv;
  tppio_byte_t eOeMux;
  tppio_byte_t statusByte;
  logic        awTake;
  logic        wTake;
  logic        arTake;

  // Pin value seen by readers: latch where output, synchronised pin where input
  function automatic tppio_byte_t read_mix(input tppio_byte_t dir, input tppio_byte_t lat,
                                           input tppio_byte_t pin);
    read_mix = (dir & lat) | (~dir & pin);
  endfunction

  // True for the six port registers; the status word is read-only and not listed
  function automatic logic reg_known(input logic [3:0] idx);
    if (idx == `TPPIO_IDX_C_DATA) begin
      reg_known = 1'b1;
    end else if (idx == `TPPIO_IDX_D_DATA) begin
      reg_known = 1'b1;
    end else if (idx == `TPPIO_IDX_E_DATA) begin
      reg_known = 1'b1;
    end else if (idx == `TPPIO_IDX_C_DIR) begin
      reg_known = 1'b1;
    end else if (idx == `TPPIO_IDX_D_DIR) begin
      reg_known = 1'b1;
    end else if (idx == `TPPIO_IDX_E_DIR) begin
      reg_known = 1'b1;
    end else begin
      reg_known = 1'b0;
    end
  endfunction

  // Per-channel: any nonzero edge/level select hands the pin to the timer
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      timerOwn[i] = |edgeLevelSelect[2*i +: 2];
    end
  end
  // Only one prescaler code routes the pin; every other code leaves it to the port
  assign clkOwn = (prescalerSelect == `TPPIO_PS_EXTCLK);
  assign serOwn = serialModuleEnable;

  // Read-only status: whether the serial module and the timer channels currently hold port E pins; the clock pin is not shown
  always_comb begin
    statusByte    = 8'h00;
    statusByte[0] = serOwn;
    statusByte[1] = |timerOwn;
  end

  // Port E output mux; timer-owned pins take direction from the timer, clock and serial pins get a fixed direction
  always_comb begin
    eDrv   = st_reg.e_latch;
    eOeMux = st_reg.e_dir;
    for (int i = 0; i < 4; i++) begin
      if (timerOwn[i]) begin
        eDrv[4+i]   = timerChannelOut[i];
        eOeMux[4+i] = timerChannelOe[i];
      end
    end
    // The clock pin is an input whenever it is selected
    if (clkOwn) begin
      eOeMux[3] = 1'b0;
    end
    if (serOwn) begin
      eDrv[2]   = serialTxd;
      eOeMux[2] = 1'b1;
      // Receive pin forced to input so a board driver never fights the block
      eOeMux[1] = 1'b0;
    end
  end

  // Ports C and D have no shared functions: latch and direction go straight out
  assign thirdPortBitsOut  = st_reg.c_latch;
  assign thirdPortBitsOe   = st_reg.c_dir;
  assign fourthPortBitsOut = st_reg.d_latch;
  assign fourthPortBitsOe  = st_reg.d_dir;
  assign fifthPortBitsOut  = eDrv;
  assign fifthPortBitsOe   = eOeMux;

  // Peripheral inputs read the synchronised pins; a pin not handed over shows
  // its receiver's idle level, so the peripheral sees no false edge
  always_comb begin
    keypadIrqInputs    = st_reg.d_s2 & keypadIrqEnables;
    timerChannelPins   = 4'h0;
    timerExternalClock = 1'b0;
    serialRxd          = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (timerOwn[i]) begin
        timerChannelPins[i] = st_reg.e_s2[4+i];
      end
    end
    if (clkOwn) begin
      timerExternalClock = st_reg.e_s2[3];
    end
    if (serOwn) begin
      serialRxd = st_reg.e_s2[1];
    end
  end

  // Address and data are taken independently; a full slot stalls only its
  // own channel until the write response is taken
  assign s_axi_awready = (st_reg.wr_state == TPPIO_IDLE) && !st_reg.aw_held;
  assign s_axi_wready  = (st_reg.wr_state == TPPIO_IDLE) && !st_reg.w_held;
  assign s_axi_bvalid  = (st_reg.wr_state == TPPIO_WRESP);
  assign s_axi_bresp   = st_reg.b_resp;
  assign s_axi_arready = (st_reg.rd_state == TPPIO_IDLE);
  assign s_axi_rvalid  = (st_reg.rd_state == TPPIO_RRESP);
  assign s_axi_rdata   = st_reg.r_data;
  assign s_axi_rresp   = st_reg.r_resp;

  // Channel hand-overs at this edge
  assign awTake = s_axi_awready && s_axi_awvalid;
  assign wTake  = s_axi_wready && s_axi_wvalid;
  assign arTake = s_axi_arready && s_axi_arvalid;

  always_comb begin
    logic [3:0]  widx;
    logic [3:0]  ridx;
    tppio_byte_t wbyte;
    logic        wbad;
    st_next = st_reg;
    widx    = st_reg.aw_addr[5:2];
    ridx    = s_axi_araddr[5:2];
    wbyte   = st_reg.w_data[7:0];
    wbad    = 1'b0;
    // Two-stage synchronisers on every pin
    // Pins run free of sys_clk; only the second stage is read anywhere
    st_next.c_s1 = thirdPortBitsIn;
    st_next.c_s2 = st_reg.c_s1;
    st_next.d_s1 = fourthPortBitsIn;
    st_next.d_s2 = st_reg.d_s1;
    st_next.e_s1 = fifthPortBitsIn;
    st_next.e_s2 = st_reg.e_s1;

    // Write channel: take address and data in either order
    if (awTake) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr[`TPPIO_ADDR_W-1:0];
      // An address beyond the block's window must not alias a register: park it on
      // an unmapped, misaligned slot so the commit answers with an error
      if (s_axi_awaddr[31:`TPPIO_ADDR_W] != '0) begin
        st_next.aw_addr = 6'h3F;
      end
    end
    if (wTake) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    // The commit waits for both halves so a lone address never writes stale data
    case (st_reg.wr_state)
      TPPIO_IDLE: begin
        if (st_reg.aw_held && st_reg.w_held) begin
          st_next.aw_held  = 1'b0;
          st_next.w_held   = 1'b0;
          st_next.wr_state = TPPIO_WRESP;
          // Only the low lane carries register bits; other lanes are ignored
          if (st_reg.w_strb[0]) begin
            if (widx == `TPPIO_IDX_C_DATA) begin
              st_next.c_latch = wbyte;
            end else if (widx == `TPPIO_IDX_D_DATA) begin
              st_next.d_latch = wbyte;
            end else if (widx == `TPPIO_IDX_E_DATA) begin
              st_next.e_latch = wbyte;
            end else if (widx == `TPPIO_IDX_C_DIR) begin
              // A new direction drives the pin from the cycle after commit
              st_next.c_dir = wbyte;
            end else if (widx == `TPPIO_IDX_D_DIR) begin
              st_next.d_dir = wbyte;
            end else if (widx == `TPPIO_IDX_E_DIR) begin
              st_next.e_dir = wbyte;
            end else begin
              wbad = 1'b1;
            end
          end else if (!reg_known(widx)) begin
            // Low lane off: a mapped word is left as it is, an unmapped one is an error
            wbad = 1'b1;
          end
          if (st_reg.aw_addr[1:0] != 2'b00) begin
            wbad = 1'b1;
          end
          if (wbad) begin
            st_next.b_resp = `TPPIO_RESP_SLVERR;
          end else begin
            st_next.b_resp = `TPPIO_RESP_OKAY;
          end
        end
      end
      TPPIO_WRESP: begin
        // Response stands until the master takes it
        if (s_axi_bready) begin
          st_next.wr_state = TPPIO_IDLE;
        end
      end
      default: begin
        st_next.wr_state = TPPIO_IDLE;
      end
    endcase

    // Read channel: one-cycle decode into a registered answer
    case (st_reg.rd_state)
      TPPIO_IDLE: begin
        if (arTake) begin
          st_next.rd_state = TPPIO_RRESP;
          st_next.r_resp   = `TPPIO_RESP_OKAY;
          // Upper bits of every register word read as zero
          st_next.r_data   = 32'h0000_0000;
          // Out-of-window and misaligned reads answer an error with zero data
          if (s_axi_araddr[31:`TPPIO_ADDR_W] != '0 || s_axi_araddr[1:0] != 2'b00) begin
            st_next.r_resp = `TPPIO_RESP_SLVERR;
          end else if (ridx == `TPPIO_IDX_C_DATA) begin
            st_next.r_data[7:0] = read_mix(st_reg.c_dir, st_reg.c_latch, st_reg.c_s2);
          end else if (ridx == `TPPIO_IDX_D_DATA) begin
            st_next.r_data[7:0] = read_mix(st_reg.d_dir, st_reg.d_latch, st_reg.d_s2);
          end else if (ridx == `TPPIO_IDX_E_DATA) begin
            // Shared pins still read by direction bit, not by owner
            st_next.r_data[7:0] = read_mix(st_reg.e_dir, st_reg.e_latch, st_reg.e_s2);
          end else if (ridx == `TPPIO_IDX_C_DIR) begin
            st_next.r_data[7:0] = st_reg.c_dir;
          end else if (ridx == `TPPIO_IDX_D_DIR) begin
            st_next.r_data[7:0] = st_reg.d_dir;
          end else if (ridx == `TPPIO_IDX_E_DIR) begin
            st_next.r_data[7:0] = st_reg.e_dir;
          end else if (ridx == `TPPIO_IDX_MUX) begin
            st_next.r_data[7:0] = statusByte;
          end else begin
            st_next.r_resp = `TPPIO_RESP_SLVERR;
          end
        end
      end
      TPPIO_RRESP: begin
        // Read answer stands until the master takes it
        if (s_axi_rready) begin
          st_next.rd_state = TPPIO_IDLE;
        end
      end
      default: begin
        st_next.rd_state = TPPIO_IDLE;
      end
    endcase
  end

  // One register process: the data latches are not named in the reset branch,
  // so they keep their contents through reset and hold while it lasts
  // Synchronisers start low; a pin held high shows two edges after release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg.c_dir    <= `TPPIO_DIR_RESET;
      st_reg.d_dir    <= `TPPIO_DIR_RESET;
      st_reg.e_dir    <= `TPPIO_DIR_RESET;
      st_reg.c_s1     <= 8'h00;
      st_reg.c_s2     <= 8'h00;
      st_reg.d_s1     <= 8'h00;
      st_reg.d_s2     <= 8'h00;
      st_reg.e_s1     <= 8'h00;
      st_reg.e_s2     <= 8'h00;
      st_reg.aw_held  <= 1'b0;
      st_reg.aw_addr  <= 6'h00;
      st_reg.w_held   <= 1'b0;
      st_reg.w_data   <= 32'h0000_0000;
      st_reg.w_strb   <= 4'h0;
      st_reg.wr_state <= TPPIO_IDLE;
      st_reg.rd_state <= TPPIO_IDLE;
      st_reg.b_resp   <= `TPPIO_RESP_OKAY;
      st_reg.r_data   <= 32'h0000_0000;
      st_reg.r_resp   <= `TPPIO_RESP_OKAY;
    end else begin
      st_reg.c_latch  <= st_next.c_latch;
      st_reg.d_latch  <= st_next.d_latch;
      st_reg.e_latch  <= st_next.e_latch;
      st_reg.c_dir    <= st_next.c_dir;
      st_reg.d_dir    <= st_next.d_dir;
      st_reg.e_dir    <= st_next.e_dir;
      st_reg.c_s1     <= st_next.c_s1;
      st_reg.c_s2     <= st_next.c_s2;
      st_reg.d_s1     <= st_next.d_s1;
      st_reg.d_s2     <= st_next.d_s2;
      st_reg.e_s1     <= st_next.e_s1;
      st_reg.e_s2     <= st_next.e_s2;
      st_reg.aw_held  <= st_next.aw_held;
      st_reg.aw_addr  <= st_next.aw_addr;
      st_reg.w_held   <= st_next.w_held;
      st_reg.w_data   <= st_next.w_data;
      st_reg.w_strb   <= st_next.w_strb;
      st_reg.wr_state <= st_next.wr_state;
      st_reg.rd_state <= st_next.rd_state;
      st_reg.b_resp   <= st_next.b_resp;
      st_reg.r_data   <= st_next.r_data;
      st_reg.r_resp   <= st_next.r_resp;
    end
  end
endmodule

/* verif/three_port_parallel_io_tb_top.sv */
// Self-checking testbench for the three-port parallel I/O block
`timescale 1ns/100ps
`include "tppio_defs.svh"
module three_port_parallel_io_tb_top;
  import tppio_pkg::*;
  logic        sys_clk = 1'b0, resetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, timerChannelOut = 4'h0, timerChannelOe = 4'h0, timerChannelPins;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        serialModuleEnable = 1'b0, serialTxd = 1'b0, serialRxd, timerExternalClock;
  logic [2:0]  prescalerSelect = 3'h0;
  tppio_byte_t thirdPortBitsIn, thirdPortBitsOut, thirdPortBitsOe, fourthPortBitsIn, fourthPortBitsOut;
  tppio_byte_t fourthPortBitsOe, fifthPortBitsIn, fifthPortBitsOut, fifthPortBitsOe, keypadIrqInputs;
  tppio_byte_t keypadIrqEnables = 8'h00, edgeLevelSelect = 8'h00, ext = 8'h3C;
  int          nFail = 0, samplesChecked = 0;
  wire [23:0]  oeAll = {fifthPortBitsOe, fourthPortBitsOe, thirdPortBitsOe};
  wire [23:0]  outAll = {fifthPortBitsOut, fourthPortBitsOut, thirdPortBitsOut};
  tppio_top i_tppio_top (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .thirdPortBitsIn, .thirdPortBitsOut,
    .thirdPortBitsOe, .fourthPortBitsIn, .fourthPortBitsOut, .fourthPortBitsOe, .fifthPortBitsIn, .fifthPortBitsOut,
    .fifthPortBitsOe, .keypadIrqEnables, .keypadIrqInputs, .edgeLevelSelect, .timerChannelOut, .timerChannelOe,
    .timerChannelPins, .prescalerSelect, .timerExternalClock, .serialModuleEnable, .serialTxd, .serialRxd);
  tppio_pads i_pads_c (.padOut(thirdPortBitsOut), .padOe(thirdPortBitsOe), .extLevel(ext), .padIn(thirdPortBitsIn));
  tppio_pads i_pads_d (.padOut(fourthPortBitsOut), .padOe(fourthPortBitsOe), .extLevel(ext), .padIn(fourthPortBitsIn));
  tppio_pads i_pads_e (.padOut(fifthPortBitsOut), .padOe(fifthPortBitsOe), .extLevel(ext), .padIn(fifthPortBitsIn));
  always #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] addr(input logic [3:0] idx);
    return {26'h000_0000, idx, 2'h0};
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    while (!s_axi_bvalid) @(posedge sys_clk);
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    chk(s_axi_bresp, er, "write response");
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, exp, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge sys_clk);
    chk(s_axi_rresp, er, "read response");
    if (er == `TPPIO_RESP_OKAY) chk(s_axi_rdata, exp, "read data");
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_port(input logic [3:0] dIdx, sIdx, input int p);
    rd(addr(sIdx), 32'h0000_0000, `TPPIO_RESP_OKAY);
    wr(addr(dIdx), 32'h0000_00A5, `TPPIO_RESP_OKAY);
    rd(addr(dIdx), 32'h0000_003C, `TPPIO_RESP_OKAY);
    wr(addr(sIdx), 32'h0000_000F, `TPPIO_RESP_OKAY);
    rd(addr(dIdx), 32'h0000_0035, `TPPIO_RESP_OKAY);
    chk(outAll[p*8 +: 8], 8'hA5, "pin drive");
    chk(oeAll[p*8 +: 8], 8'h0F, "pin enable");
    wr(addr(dIdx), 32'h0000_005A, `TPPIO_RESP_OKAY);
    rd(addr(dIdx), 32'h0000_003A, `TPPIO_RESP_OKAY);
    $display("port %0d test done", p);
  endtask
  task automatic t_keep;
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    chk(oeAll, 24'h00_0000, "enables after reset");
    wr(addr(`TPPIO_IDX_C_DIR), 32'h0000_00FF, `TPPIO_RESP_OKAY);
    rd(addr(`TPPIO_IDX_C_DATA), 32'h0000_005A, `TPPIO_RESP_OKAY);
    wr(addr(`TPPIO_IDX_D_DIR), 32'h0000_00FF, `TPPIO_RESP_OKAY);
    rd(addr(`TPPIO_IDX_D_DATA), 32'h0000_005A, `TPPIO_RESP_OKAY);
    wr(addr(`TPPIO_IDX_E_DIR), 32'h0000_00FF, `TPPIO_RESP_OKAY);
    rd(addr(`TPPIO_IDX_E_DATA), 32'h0000_005A, `TPPIO_RESP_OKAY);
    wr(32'h0000_003C, 32'h0000_00FF, `TPPIO_RESP_SLVERR);
    rd(32'h0000_003C, 32'h0000_0000, `TPPIO_RESP_SLVERR);
    wr(32'h0000_0048, 32'h0000_00FF, `TPPIO_RESP_SLVERR);
    rd(32'h0000_0048, 32'h0000_0000, `TPPIO_RESP_SLVERR);
    rd(addr(`TPPIO_IDX_C_DATA), 32'h0000_005A, `TPPIO_RESP_OKAY);
    $display("reset keep test done");
  endtask
  task automatic t_share;
    edgeLevelSelect <= 8'h03;
    prescalerSelect <= 3'h7;
    keypadIrqEnables <= 8'h0F;
    repeat (3) @(posedge sys_clk);
    chk(fifthPortBitsOe, 8'hE7, "timer and clock pins");
    chk(timerChannelPins, 4'h1, "timer capture");
    chk(timerExternalClock, 1'b1, "external clock");
    rd(addr(`TPPIO_IDX_E_DATA), 32'h0000_005A, `TPPIO_RESP_OKAY);
    wr(addr(`TPPIO_IDX_D_DIR), 32'h0000_0000, `TPPIO_RESP_OKAY);
    wr(addr(`TPPIO_IDX_E_DIR), 32'h0000_0000, `TPPIO_RESP_OKAY);
    serialModuleEnable <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(keypadIrqInputs, 8'h0C, "keypad inputs");
    chk(serialRxd, 1'b0, "receive line");
    rd(addr(`TPPIO_IDX_E_DATA), 32'h0000_0038, `TPPIO_RESP_OKAY);
    rd(addr(`TPPIO_IDX_MUX), 32'h0000_0003, `TPPIO_RESP_OKAY);
    $display("sharing test done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    t_port(`TPPIO_IDX_C_DATA, `TPPIO_IDX_C_DIR, 0);
    t_port(`TPPIO_IDX_D_DATA, `TPPIO_IDX_D_DIR, 1);
    t_port(`TPPIO_IDX_E_DATA, `TPPIO_IDX_E_DIR, 2);
    t_keep();
    t_share();
    complete_run();
  end
  initial begin
    #400000;
    nFail++;
    complete_run();
  end
endmodule

/* verif/tppio_pads.sv */
// Pad model: each pin shows the block's drive, else the external device's level
`timescale 1ns/100ps
module tppio_pads (
  // Block side
  input wire tppio_pkg::tppio_byte_t padOut,
  input wire tppio_pkg::tppio_byte_t padOe,
  // Board side
  input wire tppio_pkg::tppio_byte_t extLevel,
  output tppio_pkg::tppio_byte_t     padIn
);
  import tppio_pkg::*;
  // A released pin follows the board, never the stale drive
  assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule

/* verif/tppio_properties.sv */
// Port assertions for the three-port parallel I/O block
`timescale 1ns/100ps
module tppio_properties (
  // Clock, reset, bus
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic [1:0]             s_axi_bresp,
  // Pins and peripherals
  input wire tppio_pkg::tppio_byte_t thirdPortBitsOe,
  input wire tppio_pkg::tppio_byte_t fourthPortBitsOe,
  input wire tppio_pkg::tppio_byte_t fourthPortBitsIn,
  input wire tppio_pkg::tppio_byte_t fifthPortBitsIn,
  input wire tppio_pkg::tppio_byte_t fifthPortBitsOut,
  input wire tppio_pkg::tppio_byte_t fifthPortBitsOe,
  input wire tppio_pkg::tppio_byte_t keypadIrqEnables,
  input wire tppio_pkg::tppio_byte_t keypadIrqInputs,
  input wire logic [7:0]             edgeLevelSelect,
  input wire logic [3:0]             timerChannelOut,
  input wire logic [3:0]             timerChannelOe,
  input wire logic [3:0]             timerChannelPins,
  input wire logic [2:0]             prescalerSelect,
  input wire logic                   timerExternalClock,
  input wire logic                   serialModuleEnable,
  input wire logic                   serialTxd,
  input wire logic                   serialRxd
);
  import tppio_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  c_dir_reset_a: assert property ($rose(resetn) |-> thirdPortBitsOe == 8'h00) else $error("port C drives after reset");
  d_dir_reset_a: assert property ($rose(resetn) |-> fourthPortBitsOe == 8'h00) else $error("port D drives after reset");
  keypad_route_a: assert property ($past(resetn, 2) |-> keypadIrqInputs == ($past(fourthPortBitsIn, 2) & keypadIrqEnables))
    else $error("keypad inputs wrong");
  timer_drive_a: assert property (edgeLevelSelect[1:0] != 2'h0 |-> fifthPortBitsOe[4] == timerChannelOe[0]
    && fifthPortBitsOut[4] == timerChannelOut[0]) else $error("timer pin drive wrong");
  timer_input_a: assert property ($past(resetn, 2) |-> timerChannelPins[3] == ($past(fifthPortBitsIn[7], 2)
    && edgeLevelSelect[7:6] != 2'h0)) else $error("timer channel input wrong");
  ext_clock_a: assert property ($past(resetn, 2) |-> timerExternalClock == ($past(fifthPortBitsIn[3], 2)
    && prescalerSelect == 3'h7) && (prescalerSelect != 3'h7 || !fifthPortBitsOe[3])) else $error("clock pin wrong");
  serial_tx_a: assert property (serialModuleEnable |-> fifthPortBitsOe[2] && fifthPortBitsOut[2] == serialTxd)
    else $error("transmit pin wrong");
  serial_rx_a: assert property ($past(resetn, 2) |-> serialRxd == (serialModuleEnable ? $past(fifthPortBitsIn[1], 2)
    : 1'b1) && (!serialModuleEnable || !fifthPortBitsOe[1])) else $error("receive pin wrong");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  cover property (serialModuleEnable && fifthPortBitsOe[2]);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property (prescalerSelect == 3'h7 && edgeLevelSelect[1:0] != 2'h0);
endmodule
bind tppio_top tppio_properties i_tppio_properties (.sys_clk, .resetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .thirdPortBitsOe, .fourthPortBitsOe, .fourthPortBitsIn, .fifthPortBitsIn,
  .fifthPortBitsOut, .fifthPortBitsOe, .keypadIrqEnables, .keypadIrqInputs, .edgeLevelSelect, .timerChannelOut,
  .timerChannelOe, .timerChannelPins, .prescalerSelect, .timerExternalClock, .serialModuleEnable, .serialTxd,
  .serialRxd);
